// ==== common/hub_cfg_pkg.sv ====
// constants for the hub port configuration register bank
// assumes one byte-wide register space addressed by the configuration source
package hub_cfg_pkg;
	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int PORT_COUNT = 4;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int FIELD_MSB = 3;
	localparam int FIELD_LSB = 0;
	localparam int CUSTOM_BIT = 7;
	localparam int RSVD_MSB = 6;
	localparam int RSVD_LSB = 4;
	localparam int UPPER_MSB = 7;
	localparam int UPPER_LSB = 4;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CHARGE = 8'h06;
	localparam logic [7:0] OFS_REMOVABLE = 8'h07;
	localparam logic [7:0] OFS_USED = 8'h08;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] RST_CHARGE = 4'h0;
	localparam logic [3:0] RST_REMOVABLE = 4'h0;
	localparam logic [3:0] RST_USED = 4'hF;
	localparam logic [3:0] RST_LEGACY = 4'h0;
	localparam logic RST_CUSTOM = 1'b0;
	localparam logic [7:0] RST_READ = 8'h00;

	// ----------------------------------------------------------------
	// timing: cycles the strap pins need through the synchroniser
	// ----------------------------------------------------------------
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage : hub_cfg_pkg

// ==== common/field_if.sv ====
// carrier between the bank and one gated four-bit port field
// assumes both ends share clock_i
`timescale 1ns/10ps
interface field_if;
	logic allow;
	logic wr;
	logic [hub_cfg_pkg::FIELD_MSB:0] wr_data;
	logic [hub_cfg_pkg::FIELD_MSB:0] otp;
	logic [hub_cfg_pkg::FIELD_MSB:0] value;
	modport field (input allow, input wr, input wr_data, input otp, output value);
	modport ctrl (output allow, output wr, output wr_data, output otp, input value);
endinterface : field_if

// ==== design/strap_sync.sv ====
// two-flop synchroniser for the power control strap pins
// assumes the pins are quasi-static levels from outside the clock domain
`timescale 1ns/10ps
module strap_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] stable_r;
	logic [WIDTH-1:0] stable_nxt;

	if (WIDTH < 1) begin : g_bad_width
		$error("strap_sync needs WIDTH of one or more");
	end

	always_comb begin
		meta_nxt = async_i;
		stable_nxt = meta_r;
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			meta_r <= '0;
			stable_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			stable_r <= stable_nxt;
		end
	end

	assign sync_o = stable_r;
endmodule : strap_sync

// ==== design/port_field_reg.sv ====
// one four-bit port field that follows its otp value while locked
// assumes the bank drives allow from the custom write bit
`timescale 1ns/10ps
module port_field_reg #(
	parameter logic [3:0] RESET_VAL = 4'h0
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	field_if.field bus
);
	logic [hub_cfg_pkg::FIELD_MSB:0] value_r;
	logic [hub_cfg_pkg::FIELD_MSB:0] value_nxt;

	// ----------------------------------------------------------------
	// next value
	// ----------------------------------------------------------------
	always_comb begin
		value_nxt = value_r;
		if (!bus.allow) begin
			value_nxt = bus.otp;
		end else if (bus.wr) begin
			value_nxt = bus.wr_data;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			value_r <= RESET_VAL;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign bus.value = value_r;

	a_locked_follows_otp: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!bus.allow |=> bus.value == $past(bus.otp))
		else $error("locked field did not follow otp");
	a_open_keeps_value: assert property (@(posedge clock_i) disable iff (!rstn_i)
		bus.allow && !bus.wr |=> $stable(bus.value))
		else $error("open field changed without a write");
endmodule : port_field_reg

// ==== design/hub_port_config_regs.sv ====
// configuration bank for the four downstream ports of the hub
// assumes one write/read port from the eeprom loader or smbus slave on clock_i,
// otp values valid and stable on clock_i, strap pins asynchronous
//
// Overview of operation
// - each charge bit enables battery charging on its port when one
// - bit 7 of the removable register gates writes to the port fields
// - with the custom bit clear, port fields are read-only and follow otp
// - with the custom bit set, port fields accept eeprom and smbus writes
// - one write may set the custom bit and new removable flags together
// - removable register bits 6 to 4 are read-only and read zero
// - removable bit n is port n+1; one removable, zero permanent
// - locked removable field reads as inverse of otp non-removable field
// - used bit one means port used and enabled, zero unused
// - used bit 0 is port 1, ascending up to port 4
// - used field ignores writes unless the custom bit is set
// - a set legacy-speed-only bit enables the port's usb2 side regardless
`timescale 1ns/10ps
module hub_port_config_regs #(
	parameter int PORT_COUNT = hub_cfg_pkg::PORT_COUNT
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [7:0] rd_addr_i,
	input wire logic legacy_wr_i,
	input wire logic [3:0] legacy_data_i,
	input wire logic [3:0] otp_non_removable_i,
	input wire logic [3:0] otp_used_i,
	input wire logic [3:0] otp_legacy_i,
	input wire logic [3:0] power_ctrl_strap_pins_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic [3:0] charge_port_enable_bits_o,
	output logic custom_write_allow_o,
	output logic [3:0] removable_o,
	output logic [3:0] used_o,
	output logic [3:0] legacy_speed_only_flags_o,
	output logic [3:0] usb2_port_enable_o
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// the byte layout holds exactly four port bits below the upper nibble
	if (PORT_COUNT != hub_cfg_pkg::PORT_COUNT) begin : g_bad_ports
		$error("hub_port_config_regs serves four ports only");
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [3:0] strap_sync;
	logic [1:0] settle_r;
	logic [1:0] settle_nxt;
	logic loaded_r;
	logic loaded_nxt;
	logic [3:0] charge_r;
	logic [3:0] charge_nxt;
	logic custom_r;
	logic custom_nxt;
	logic [3:0] usb2_en_r;
	logic [3:0] usb2_en_nxt;
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic rd_valid_r;
	logic rd_valid_nxt;
	logic wr_charge;
	logic wr_removable;
	logic wr_used;

	field_if rem_if ();
	field_if used_if ();
	field_if legacy_if ();

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	assign wr_charge = wr_en_i && (wr_addr_i == hub_cfg_pkg::OFS_CHARGE);
	assign wr_removable = wr_en_i && (wr_addr_i == hub_cfg_pkg::OFS_REMOVABLE);
	assign wr_used = wr_en_i && (wr_addr_i == hub_cfg_pkg::OFS_USED);

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	// the pins are sampled only after the synchroniser has refilled
	// following reset, so stale flop contents never reach the field
	strap_sync #(
		.WIDTH(4)
	) u_strap_sync (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.async_i(power_ctrl_strap_pins_i),
		.sync_o(strap_sync)
	);

	always_comb begin
		settle_nxt = settle_r;
		loaded_nxt = loaded_r;
		if (settle_r != hub_cfg_pkg::STRAP_SETTLE) begin
			settle_nxt = settle_r + 2'h1;
		end else begin
			loaded_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			settle_r <= 2'h0;
			loaded_r <= 1'b0;
		end else begin
			settle_r <= settle_nxt;
			loaded_r <= loaded_nxt;
		end
	end

	// ----------------------------------------------------------------
	// charge enable field
	// ----------------------------------------------------------------
	// a write in the strap load cycle wins: software intent beats default
	always_comb begin
		charge_nxt = charge_r;
		if (settle_r == hub_cfg_pkg::STRAP_SETTLE && !loaded_r) begin
			charge_nxt = strap_sync;
		end
		if (wr_charge) begin
			charge_nxt = wr_data_i[hub_cfg_pkg::FIELD_MSB:hub_cfg_pkg::FIELD_LSB];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			charge_r <= hub_cfg_pkg::RST_CHARGE;
		end else begin
			charge_r <= charge_nxt;
		end
	end

	// ----------------------------------------------------------------
	// custom write bit
	// ----------------------------------------------------------------
	always_comb begin
		custom_nxt = custom_r;
		if (wr_removable) begin
			custom_nxt = wr_data_i[hub_cfg_pkg::CUSTOM_BIT];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			custom_r <= hub_cfg_pkg::RST_CUSTOM;
		end else begin
			custom_r <= custom_nxt;
		end
	end

	// ----------------------------------------------------------------
	// gated port fields
	// ----------------------------------------------------------------
	// allow uses the incoming custom bit so that one access can open
	// the field and carry its new flags
	assign rem_if.allow = custom_nxt;
	assign rem_if.wr = wr_removable;
	assign rem_if.wr_data = wr_data_i[hub_cfg_pkg::FIELD_MSB:hub_cfg_pkg::FIELD_LSB];
	assign rem_if.otp = ~otp_non_removable_i;

	assign used_if.allow = custom_nxt;
	assign used_if.wr = wr_used;
	assign used_if.wr_data = wr_data_i[hub_cfg_pkg::FIELD_MSB:hub_cfg_pkg::FIELD_LSB];
	assign used_if.otp = otp_used_i;

	assign legacy_if.allow = custom_nxt;
	assign legacy_if.wr = legacy_wr_i;
	assign legacy_if.wr_data = legacy_data_i;
	assign legacy_if.otp = otp_legacy_i;

	port_field_reg #(
		.RESET_VAL(hub_cfg_pkg::RST_REMOVABLE)
	) u_removable (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.bus(rem_if.field)
	);

	port_field_reg #(
		.RESET_VAL(hub_cfg_pkg::RST_USED)
	) u_used (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.bus(used_if.field)
	);

	port_field_reg #(
		.RESET_VAL(hub_cfg_pkg::RST_LEGACY)
	) u_legacy (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.bus(legacy_if.field)
	);

	// ----------------------------------------------------------------
	// usb2 side enable
	// ----------------------------------------------------------------
	// registered from the held fields, so it lags them by one cycle
	always_comb begin
		usb2_en_nxt = used_if.value | legacy_if.value;
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			usb2_en_r <= hub_cfg_pkg::RST_USED | hub_cfg_pkg::RST_LEGACY;
		end else begin
			usb2_en_r <= usb2_en_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		rd_data_nxt = rd_data_r;
		rd_valid_nxt = rd_en_i;
		if (rd_en_i) begin
			case (rd_addr_i)
				hub_cfg_pkg::OFS_CHARGE: begin
					rd_data_nxt = {4'h0, charge_r};
				end
				hub_cfg_pkg::OFS_REMOVABLE: begin
					rd_data_nxt = {custom_r, 3'h0, rem_if.value};
				end
				hub_cfg_pkg::OFS_USED: begin
					rd_data_nxt = {4'h0, used_if.value};
				end
				default: begin
					rd_data_nxt = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rd_data_r <= hub_cfg_pkg::RST_READ;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rd_data_o = rd_data_r;
	assign rd_valid_o = rd_valid_r;
	assign charge_port_enable_bits_o = charge_r;
	assign custom_write_allow_o = custom_r;
	assign removable_o = rem_if.value;
	assign used_o = used_if.value;
	assign legacy_speed_only_flags_o = legacy_if.value;
	assign usb2_port_enable_o = usb2_en_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_charge_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wr_charge |=> charge_port_enable_bits_o == $past(wr_data_i[3:0]))
		else $error("charge field missed its write");
	a_custom_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wr_removable |=> custom_write_allow_o == $past(wr_data_i[7]))
		else $error("custom bit missed its write");
	a_used_locked: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!custom_write_allow_o && !wr_removable |=> used_o == $past(otp_used_i))
		else $error("locked used field left otp value");
	a_used_open: assert property (@(posedge clock_i) disable iff (!rstn_i)
		custom_write_allow_o && !wr_removable && wr_used
		|=> used_o == $past(wr_data_i[3:0]))
		else $error("open used field missed its write");
	a_same_access: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wr_removable && wr_data_i[7]
		|=> custom_write_allow_o && removable_o == $past(wr_data_i[3:0]))
		else $error("custom bit and flags not taken together");
	a_rsvd_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
		rd_en_i && rd_addr_i == hub_cfg_pkg::OFS_REMOVABLE
		|=> rd_valid_o && rd_data_o[6:4] == 3'h0
		&& rd_data_o[3:0] == $past(removable_o))
		else $error("removable read wrong");
	a_removable_invert: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!custom_write_allow_o && !wr_removable
		|=> removable_o == ~$past(otp_non_removable_i))
		else $error("locked removable is not otp inverse");
	a_used_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
		rd_en_i && rd_addr_i == hub_cfg_pkg::OFS_USED
		|=> rd_data_o == {4'h0, $past(used_o)})
		else $error("used read wrong");
	a_usb2_override: assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 usb2_port_enable_o == ($past(used_o) | $past(legacy_speed_only_flags_o)))
		else $error("usb2 enable ignores legacy flag");
	a_used_reset: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(rstn_i) |-> used_o == 4'hF && rd_data_o == 8'h00)
		else $error("used field not all ones after reset");
	a_strap_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(rstn_i) ##2 !wr_charge
		|=> charge_port_enable_bits_o == $past(strap_sync))
		else $error("strap value not loaded");
endmodule : hub_port_config_regs

// ==== test/cfg_source.sv ====
// model of the configuration source: eeprom loader or smbus host
// assumes the bank takes each request on the rising edge of clock_i
`timescale 1ns/10ps
module cfg_source (
	input wire logic clock_i,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	output logic wr_en_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic rd_en_o,
	output logic [7:0] rd_addr_o,
	output logic legacy_wr_o,
	output logic [3:0] legacy_data_o
);
	initial begin
		wr_en_o = 1'b0;
		wr_addr_o = 8'h00;
		wr_data_o = 8'h00;
		rd_en_o = 1'b0;
		rd_addr_o = 8'h00;
		legacy_wr_o = 1'b0;
		legacy_data_o = 4'h0;
	end

	// ----------------------------------------------------------------
	// requests: raised after a falling edge, dropped after the taking edge
	// ----------------------------------------------------------------
	// released lines show the inverse so a stale value is never trusted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		// keep port 3 on whenever port 1 would be switched off
		if (a == hub_cfg_pkg::OFS_USED && !v[0] && !v[2]) begin
			v[2] = 1'b1;
		end
		@(negedge clock_i);
		wr_en_o = 1'b1;
		wr_addr_o = a;
		wr_data_o = v;
		@(posedge clock_i);
		@(negedge clock_i);
		wr_en_o = 1'b0;
		wr_addr_o = ~a;
		wr_data_o = ~v;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge clock_i);
		rd_en_o = 1'b1;
		rd_addr_o = a;
		@(posedge clock_i);
		@(negedge clock_i);
		rd_en_o = 1'b0;
		rd_addr_o = ~a;
		ok = rd_valid_i;
		d = rd_data_i;
	endtask : rd

	task automatic lw(input logic [3:0] d);
		@(negedge clock_i);
		legacy_wr_o = 1'b1;
		legacy_data_o = d;
		@(posedge clock_i);
		@(negedge clock_i);
		legacy_wr_o = 1'b0;
		legacy_data_o = ~d;
	endtask : lw
endmodule : cfg_source

// ==== test/tb_top.sv ====
// self-checking bench for the hub port configuration bank
// assumes cfg_source drives the register and legacy ports
`timescale 1ns/10ps
module tb_top;
	typedef struct packed {
		logic [7:0] wa;
		logic [7:0] wd;
		logic [7:0] ra;
		logic [7:0] exp;
	} row_t;

	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] otp_nrm = 4'h3;
	logic [3:0] otp_used = 4'h5;
	logic [3:0] otp_leg = 4'h0;
	logic [3:0] straps = 4'hA;
	logic wr_en, rd_en, legacy_wr, rd_valid, custom;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data, got;
	logic [3:0] legacy_data, charge, removable, used, legacy, usb2_en;
	logic ok;
	int err_total = 0;
	int n_tests = 0;
	int cycles = 0;
	row_t rows [8] = '{
		'{8'h06, 8'hFF, 8'h06, 8'h0F},
		'{8'h08, 8'h03, 8'h08, 8'h05},
		'{8'h07, 8'h0A, 8'h07, 8'h0C},
		'{8'h07, 8'hF5, 8'h07, 8'h85},
		'{8'h08, 8'hFE, 8'h08, 8'h0E},
		'{8'h09, 8'hFF, 8'h09, 8'h00},
		'{8'h07, 8'h00, 8'h08, 8'h05},
		'{8'h00, 8'h00, 8'h07, 8'h0C}
	};

	always #50 clock_i = ~clock_i;

	hub_port_config_regs dut (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.wr_en_i(wr_en),
		.wr_addr_i(wr_addr),
		.wr_data_i(wr_data),
		.rd_en_i(rd_en),
		.rd_addr_i(rd_addr),
		.legacy_wr_i(legacy_wr),
		.legacy_data_i(legacy_data),
		.otp_non_removable_i(otp_nrm),
		.otp_used_i(otp_used),
		.otp_legacy_i(otp_leg),
		.power_ctrl_strap_pins_i(straps),
		.rd_data_o(rd_data),
		.rd_valid_o(rd_valid),
		.charge_port_enable_bits_o(charge),
		.custom_write_allow_o(custom),
		.removable_o(removable),
		.used_o(used),
		.legacy_speed_only_flags_o(legacy),
		.usb2_port_enable_o(usb2_en)
	);

	cfg_source src (
		.clock_i(clock_i),
		.rd_data_i(rd_data),
		.rd_valid_i(rd_valid),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.rd_en_o(rd_en),
		.rd_addr_o(rd_addr),
		.legacy_wr_o(legacy_wr),
		.legacy_data_o(legacy_data)
	);

	// ----------------------------------------------------------------
	// compare and report
	// ----------------------------------------------------------------
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: byte %h expected %h", $time, g, e);
		end
	endtask : chk8

	task automatic chk4(input logic [3:0] g, input logic [3:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: field %h expected %h", $time, g, e);
		end
	endtask : chk4

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	// the whole run needs about 65 cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 1000) begin
			err_total++;
			test_done();
		end
	end

	task automatic reset_check();
		repeat (5) @(negedge clock_i);
		chk4(used, 4'hF);
		chk4({3'h0, custom}, 4'h0);
		chk4(charge, 4'h0);
		chk4(usb2_en, 4'hF);
	endtask : reset_check

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(negedge clock_i);
		reset_check();
		rstn_i = 1'b1;
		// charge bits pick up the strap levels three edges after release
		repeat (4) @(negedge clock_i);
		chk4(charge, 4'hA);
		foreach (rows[i]) begin
			src.wr(rows[i].wa, rows[i].wd);
			src.rd(rows[i].ra, got, ok);
			chk4({3'h0, ok}, 4'h1);
			chk8(got, rows[i].exp);
		end
		src.wr(8'h07, 8'h86);
		chk4({3'h0, custom}, 4'h1);
		chk4(removable, 4'h6);
		// differs from the otp value so an ignored write would show
		src.wr(8'h08, 8'h0D);
		chk4(used, 4'hD);
		src.lw(4'hA);
		chk4(legacy, 4'hA);
		@(negedge clock_i);
		chk4(usb2_en, 4'hF);
		src.wr(8'h07, 8'h00);
		src.lw(4'h3);
		chk4(legacy, 4'h0);
		chk4(removable, 4'hC);
		@(negedge clock_i);
		rstn_i = 1'b0;
		reset_check();
		rstn_i = 1'b1;
		// straps reload and locked fields return to otp after a mid-run reset
		repeat (4) @(negedge clock_i);
		chk4(charge, 4'hA);
		chk4(used, 4'h5);
		chk4(removable, 4'hC);
		test_done();
	end
endmodule : tb_top
